// ---- cbcs_bus_cycle.v ----
`timescale 1ns/1ps
`include "cbcs_regs.vh"
module cbcs_bus_cycle #(
    parameter DW = 64
) (
    input  wire          clk,
    input  wire          reset_n,
    input  wire          req_valid,
    input  wire [2:0]    req_type,
    input  wire [1:0]    req_subtype,
    input  wire          req_len128,
    input  wire          req_cacheable,
    input  wire [7:0]    req_byte_en,
    input  wire          req_pfld,
    input  wire          dc_hit_modified,
    input  wire [DW-1:0] dc_data,
    input  wire          hold,
    input  wire          bus_backoff_n,
    input  wire          burst_ready_n,
    input  wire          cache_permit_n,
    input  wire [DW-1:0] bus_data_in,
    input  wire          bus_request_in,
    input  wire          snoop_match_in,
    input  wire          snoop_dirty_in,
    input  wire          atomic_in,
    input  wire          parity_err_in,
    output reg           req_ready,
    output reg           cycle_start_n,
    output reg           cycle_start_n_oe_n,
    output reg           mem_or_io,
    output reg           data_or_code,
    output reg           write_or_read,
    output reg           page_walk_cycle,
    output reg           transfer_subtype,
    output reg           double_width_len,
    output reg           cache_n,
    output reg  [7:0]    byte_lane_select_n,
    output reg           bus_group_oe_n,
    output reg           hold_acknowledge,
    output reg           bus_request_out,
    output reg           snoop_match_n,
    output reg           snoop_match_dirty_n,
    output reg           atomic_n,
    output reg           parity_error_out_n,
    output reg           pfld_valid,
    output reg  [DW-1:0] pfld_data,
    output reg           dc_alloc
);
    localparam S_IDLE = 2'h0;
    localparam S_ADDR = 2'h1;
    localparam S_DATA = 2'h2;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [2:0] beats_q;
    reg       backoff_q;
    reg       pfld_q;
    reg       cur_mem_rd_q;
    wire      pipe_vld;
    wire [DW-1:0] pipe_data;
    wire      backoff = ~bus_backoff_n;
    wire      float_now = hold_acknowledge | backoff;
    wire      beat = (state_q == S_DATA) & ~burst_ready_n & ~backoff;
    wire      pf_hit = req_valid & req_ready & req_pfld & dc_hit_modified;

    function [2:0] cbcs_beats;
        input ln;
        input cch;
        input knp;
        begin
            if (cch & ~knp)
                cbcs_beats = `CBCS_BEATS_LINE;
            else if (ln)
                cbcs_beats = `CBCS_BEATS_QUAD;
            else
                cbcs_beats = `CBCS_BEATS_SINGLE;
        end
    endfunction

    cbcs_pfld_pipe #(.DW(DW)) u_pipe (
        .clk       (clk),
        .reset_n   (reset_n),
        .push      (pf_hit | (pfld_q & beat)),
        .push_data (pf_hit ? dc_data : bus_data_in),
        .pop_valid (pipe_vld),
        .pop_data  (pipe_data)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (req_valid & req_ready & ~pf_hit & ~float_now)
                    state_d = S_ADDR;
            end
            S_ADDR: begin
                state_d = S_DATA;
            end
            S_DATA: begin
                if (beat & (beats_q == 3'h1))
                    state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    wire hold_grant = hold & (state_q == S_IDLE);
    wire start      = (state_q == S_IDLE) & (state_d == S_ADDR);

    // control state; inputs taken synchronously, reset asynchronous
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= S_IDLE;
            backoff_q <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            backoff_q <= backoff;
            req_ready <= (state_d == S_IDLE) & ~float_now & ~hold;
            if (backoff && state_q != S_IDLE) begin
                state_q <= S_IDLE;
            end else begin
                state_q <= state_d;
            end
        end
    end

    // always-driven sideband, active low where _n
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_request_out     <= 1'b0;
            snoop_match_n       <= 1'b1;
            snoop_match_dirty_n <= 1'b1;
            atomic_n            <= 1'b1;
            parity_error_out_n  <= 1'b1;
        end else begin
            bus_request_out     <= bus_request_in;
            snoop_match_n       <= ~snoop_match_in;
            snoop_match_dirty_n <= ~snoop_dirty_in;
            atomic_n            <= ~atomic_in;
            parity_error_out_n  <= ~parity_err_in;
        end
    end

    // float on hold ack or backoff, strobe a clock later on backoff
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_acknowledge   <= 1'b0;
            bus_group_oe_n     <= 1'b0;
            cycle_start_n_oe_n <= 1'b0;
        end else begin
            hold_acknowledge   <= hold_grant;
            bus_group_oe_n     <= float_now | hold_grant;
            cycle_start_n_oe_n <= hold_grant | hold_acknowledge | (backoff & backoff_q);
        end
    end

    // strobe and cycle definition, latched at cycle start
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cycle_start_n      <= 1'b1;
            mem_or_io          <= 1'b0;
            data_or_code       <= 1'b0;
            write_or_read      <= 1'b0;
            page_walk_cycle    <= 1'b0;
            transfer_subtype   <= 1'b0;
            double_width_len   <= 1'b0;
            cache_n            <= 1'b1;
            byte_lane_select_n <= 8'hFF;
        end else begin
            cycle_start_n <= ~start;
            if (start) begin
                {mem_or_io, data_or_code, write_or_read} <= req_type;
                if (req_type == `CBCS_CYC_MEM_RD || req_type == `CBCS_CYC_MEM_WR) begin
                    {page_walk_cycle, transfer_subtype} <= req_subtype;
                end else begin
                    {page_walk_cycle, transfer_subtype} <= 2'h0;
                end
                double_width_len   <= req_len128;
                cache_n            <= ~(req_cacheable & ~req_pfld);
                byte_lane_select_n <= ~req_byte_en;
            end
        end
    end

    // beat count, set at start and trimmed when no line fill
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            beats_q      <= 3'h0;
            pfld_q       <= 1'b0;
            cur_mem_rd_q <= 1'b0;
        end else begin
            if (start) begin
                beats_q      <= cbcs_beats(req_len128, req_cacheable & ~req_pfld, 1'b0);
                pfld_q       <= req_pfld;
                cur_mem_rd_q <= (req_type == `CBCS_CYC_MEM_RD);
            end else if (state_q == S_ADDR) begin
                if (cache_n | cache_permit_n) begin
                    beats_q <= cbcs_beats(double_width_len, 1'b0, 1'b1);
                end
            end else if (beat) begin
                beats_q <= beats_q - 3'h1;
            end
        end
    end

    // load pipe output and cache allocation pulse
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pfld_valid <= 1'b0;
            pfld_data  <= {DW{1'b0}};
            dc_alloc   <= 1'b0;
        end else begin
            pfld_valid <= pipe_vld;
            pfld_data  <= pipe_data;
            // fills allocate only when not pipelined load
            dc_alloc   <= beat & cur_mem_rd_q & ~pfld_q & ~cache_n & ~cache_permit_n;
        end
    end
endmodule

// ---- cbcs_regs.vh ----
// Behaviour
// - encode cycle type on three definition outputs
// - sideband outputs always driven, others tristate
// - float bus on hold ack or backoff
// - pipelined load hit-modified forwards cached data
// - pipelined load never allocates data cache
// - names ending _n are active low
// - memory data cycles carry page and subtype
// - line fill four beats, 128-bit two
// - cycle start strobe lasts exactly one clock
`ifndef CBCS_REGS_VH
`define CBCS_REGS_VH
`define CBCS_CYC_INTA      3'h0
`define CBCS_CYC_SPECIAL   3'h1
`define CBCS_CYC_IO_RD     3'h2
`define CBCS_CYC_IO_WR     3'h3
`define CBCS_CYC_CODE_RD   3'h4
`define CBCS_CYC_RSVD      3'h5
`define CBCS_CYC_MEM_RD    3'h6
`define CBCS_CYC_MEM_WR    3'h7
`define CBCS_SUB_NORMAL    2'h0
`define CBCS_SUB_PFLD      2'h1
`define CBCS_SUB_PDIR      2'h2
`define CBCS_SUB_PTBL      2'h3
`define CBCS_SUB_WTHRU     2'h0
`define CBCS_SUB_WBACK     2'h1
`define CBCS_BEATS_LINE    3'h4
`define CBCS_BEATS_QUAD    3'h2
`define CBCS_BEATS_SINGLE  3'h1
`define CBCS_PIPE_DEPTH    3
`endif

// ---- cbcs_pfld_pipe.v ----
`timescale 1ns/1ps
`include "cbcs_regs.vh"
module cbcs_pfld_pipe #(
    parameter DW = 64
) (
    input  wire          clk,
    input  wire          reset_n,
    input  wire          push,
    input  wire [DW-1:0] push_data,
    output wire          pop_valid,
    output wire [DW-1:0] pop_data
);
    reg [DW-1:0] stage_q [0:`CBCS_PIPE_DEPTH-1];
    reg [`CBCS_PIPE_DEPTH-1:0] vld_q;
    integer i;
    // three-stage load pipe, shifts on each push
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vld_q <= {`CBCS_PIPE_DEPTH{1'b0}};
            for (i = 0; i < `CBCS_PIPE_DEPTH; i = i + 1)
                stage_q[i] <= {DW{1'b0}};
        end else if (push) begin
            vld_q    <= {vld_q[`CBCS_PIPE_DEPTH-2:0], 1'b1};
            stage_q[0] <= push_data;
            for (i = 1; i < `CBCS_PIPE_DEPTH; i = i + 1)
                stage_q[i] <= stage_q[i-1];
        end
    end
    assign pop_valid = vld_q[`CBCS_PIPE_DEPTH-1] & push;
    assign pop_data  = stage_q[`CBCS_PIPE_DEPTH-1];
endmodule

// ---- cbcs_bus_cycle_monitor.sv ----
`timescale 1ns/1ps
module cbcs_bus_cycle_monitor (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       req_pfld,
    input wire logic       dc_hit_modified,
    input wire logic       bus_backoff_n,
    input wire logic       hold,
    input wire logic       bus_request_in,
    input wire logic       cycle_start_n,
    input wire logic       cycle_start_n_oe_n,
    input wire logic       mem_or_io,
    input wire logic       data_or_code,
    input wire logic       write_or_read,
    input wire logic       bus_group_oe_n,
    input wire logic       hold_acknowledge,
    input wire logic       bus_request_out,
    input wire logic       dc_alloc,
    input wire logic [2:0] req_type
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire take = req_valid && req_ready && bus_backoff_n;
    wire fwd = take && req_pfld && dc_hit_modified;
    a_strobe_one_clock: assert property (!cycle_start_n |=> cycle_start_n)
        else $error("strobe too long");
    a_strobe_on_take: assert property (take && !fwd |=> !cycle_start_n)
        else $error("no strobe after take");
    a_cycle_type_code: assert property (take && !fwd |=>
        {mem_or_io, data_or_code, write_or_read} == $past(req_type)) else $error("bad type");
    a_pfld_no_bus: assert property (fwd |=> cycle_start_n)
        else $error("forwarded load made bus cycle");
    a_pfld_no_alloc: assert property (take && req_pfld |=> !dc_alloc [*4])
        else $error("pipelined load allocated");
    a_backoff_float: assert property (!bus_backoff_n |-> ##[1:2] bus_group_oe_n)
        else $error("bus not floated");
    a_strobe_float: assert property (!bus_backoff_n [*2] |-> ##[1:2] cycle_start_n_oe_n)
        else $error("strobe not floated");
    a_hold_float: assert property (hold_acknowledge [*2] |-> bus_group_oe_n)
        else $error("bus driven in hold");
    a_ack_needs_hold: assert property ($rose(hold_acknowledge) |-> $past(hold))
        else $error("ack without hold");
    a_sideband_driven: assert property ($rose(bus_request_in) |=> bus_request_out)
        else $error("request out lost");
    c_fwd: cover property (fwd);
    c_backoff: cover property (!bus_backoff_n [*3]);
    c_hold: cover property (hold_acknowledge);
endmodule
bind cbcs_bus_cycle cbcs_bus_cycle_monitor i_cbcs_bus_cycle_monitor (.*);

// ---- cbcs_mem_model.sv ----
`timescale 1ns/1ps
module cbcs_mem_model (
    input  wire logic       clk, cycle_start_n, cache_n, double_width_len,
    input  wire logic       cache_permit_n, bus_backoff_n,
    input  wire logic [1:0] dly,
    output logic            burst_ready_n = 1'b1,
    output logic [63:0]     bus_data_in = 64'h0
);
    int beats = 0;
    int wt = 0;
    // data bus inverts every clock, so back-to-back beats differ
    always @(posedge clk) begin
        burst_ready_n <= 1'b1;
        bus_data_in <= ~bus_data_in;
        if (!bus_backoff_n) begin
            beats = 0;
        end else if (!cycle_start_n) begin
            beats = (!cache_n && !cache_permit_n) ? 4 : double_width_len ? 2 : 1;
            wt = dly;
        end else if (beats > 0 && wt > 0) begin
            wt--;
        end else if (beats > 0) begin
            burst_ready_n <= 1'b0;
            beats--;
        end
    end
endmodule

// ---- cbcs_bus_cycle_test.sv ----
`timescale 1ns/1ps
module cbcs_bus_cycle_test;
    logic clk = 0, reset_n = 0, req_valid = 0, req_len128 = 0, req_cacheable = 0, req_pfld = 0;
    logic dc_hit_modified = 0, hold = 0, bus_backoff_n = 1, cache_permit_n = 1;
    logic bus_request_in = 0, snoop_match_in = 0, snoop_dirty_in = 0, atomic_in = 0;
    logic parity_err_in = 0;
    logic [2:0] req_type = 0;
    logic [1:0] req_subtype = 0, dly = 0;
    logic [7:0] req_byte_en = 0, byte_lane_select_n;
    logic [63:0] dc_data = 0, bus_data_in, pfld_data, q[$];
    logic burst_ready_n, req_ready, cycle_start_n, cycle_start_n_oe_n, mem_or_io, data_or_code;
    logic write_or_read, page_walk_cycle, transfer_subtype, double_width_len, cache_n;
    logic bus_group_oe_n, hold_acknowledge, bus_request_out, snoop_match_n, snoop_match_dirty_n;
    logic atomic_n, parity_error_out_n, pfld_valid, dc_alloc;
    int errors = 0, num_checks = 0;
    logic pf_bus = 0, up = 0;
    logic [4:0] sb_q = 0;
    wire [4:0] sb_seen = {bus_request_out, ~snoop_match_n, ~snoop_match_dirty_n, ~atomic_n,
                          ~parity_error_out_n};
    cbcs_bus_cycle i_cbcs_bus_cycle (.*);
    cbcs_mem_model i_cbcs_mem_model (.*);
    always #4 clk = ~clk;
    task conclude;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task lim(input int n);
        if (n >= 40) begin
            errors++;
            conclude;
        end
    endtask
    always @(posedge clk) begin
        if (up) chk("sideband", sb_q, sb_seen);
        up <= reset_n;
        sb_q <= {bus_request_in, snoop_match_in, snoop_dirty_in, atomic_in, parity_err_in};
        {bus_request_in, snoop_match_in, snoop_dirty_in, atomic_in, parity_err_in} <= $urandom;
        if (pfld_valid === 1'b1) chk("pfld_data", q.pop_front(), pfld_data);
        if (pf_bus && burst_ready_n === 1'b0) q.push_back(bus_data_in);
    end
    task automatic run(input logic [2:0] t, input logic pf, hm, bo);
        int n, na;
        logic [63:0] d;
        d = {$urandom, $urandom};
        @(posedge clk);
        {req_valid, req_type, req_pfld, dc_hit_modified, dc_data} <= {1'b1, t, pf, hm, d};
        {req_cacheable, req_len128, cache_permit_n, req_subtype, dly} <= $urandom;
        req_byte_en <= $urandom;
        n = 0;
        do @(posedge clk); while (req_ready !== 1'b1 && ++n < 40);
        lim(n);
        req_valid <= 0;
        if (pf && hm) q.push_back(d);
        else begin
            pf_bus = pf;
            n = 0;
            do @(posedge clk); while (cycle_start_n !== 1'b0 && ++n < 40);
            lim(n);
            chk("cycle type", t, {mem_or_io, data_or_code, write_or_read});
            chk("byte lanes", {~req_byte_en}, byte_lane_select_n);
            chk("page cycle", (t[2:1] == 2'h3) ? req_subtype : 2'h0,
                {page_walk_cycle, transfer_subtype});
            chk("length", req_len128, double_width_len);
            chk("cache", !(req_cacheable && !pf), cache_n);
            if (bo) begin
                bus_backoff_n <= 0;
                repeat (4) @(posedge clk);
                chk("float", 2'h3, {bus_group_oe_n, cycle_start_n_oe_n});
                bus_backoff_n <= 1;
            end
            na = 0;
            do begin @(posedge clk); na += dc_alloc; end while (req_ready !== 1'b1 && ++n < 40);
            lim(n);
            pf_bus = 0;
            if (t == 3'h6 && !bo)
                chk("fills", (req_cacheable && !cache_permit_n && !pf) ? 4 : 0, na);
        end
    endtask
    initial begin
        int n;
        void'($urandom(60));
        repeat (6) @(posedge clk);
        reset_n <= 1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 24; i++) run(i % 8, 0, 0, 0);
        repeat (5) run(3'h6, 1, 1, 0);
        repeat (2) @(posedge clk);
        chk("pipe depth", 3, q.size());
        repeat (2) run(3'h6, 1, 0, 0);
        repeat (2) @(posedge clk);
        chk("pipe depth", 3, q.size());
        run(3'h7, 0, 0, 1);
        hold <= 1;
        n = 0;
        do @(posedge clk); while (hold_acknowledge !== 1'b1 && ++n < 40);
        lim(n);
        @(posedge clk);
        chk("hold float", 2'h3, {bus_group_oe_n, cycle_start_n_oe_n});
        hold <= 0;
        repeat (4) @(posedge clk);
        conclude;
    end
endmodule
